// >>> include/gsp_pkg.sv
/*
 * Shared constants, types and state codes of the superchannel packetizer.
 * Assumes a single sample-clock domain and no software-visible registers.
 */
package gsp_pkg;
   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int NUM_BANKS = 4;
   localparam int NUM_ADC = 4;
   localparam int ADC_W = 16;
   localparam int BB_W = 17;
   localparam int CH_W = 24;
   localparam int SC_W = 26;
   localparam int GROUP = 4;
   localparam int IDX_W = 9;
   localparam int SC_IDX_W = 7;
   localparam int MASK_W = 94;
   localparam logic [IDX_W-1:0] CH_LARGE = 9'd375;
   localparam logic [IDX_W-1:0] CH_SMALL = 9'd175;
   localparam int SC_LARGE = 94;
   localparam int SC_SMALL = 44;
   localparam int CH_SPACING_KHZ = 200;
   localparam logic [NUM_BANKS-1:0] LARGE_BANKS = 4'h3;

   // ------------------------------------------------------------------
   // Output-rate generator: sample clock times 13 / 2160
   // ------------------------------------------------------------------
   localparam logic [11:0] RATE_NUM = 12'd13;
   localparam logic [11:0] RATE_DEN = 12'd2160;
   localparam logic [7:0] RATE_GAP_MIN = 8'd166;
   localparam logic [7:0] RATE_GAP_MAX = 8'd167;

   // Quarter-turn offsets of the four channels in a group: -1/4, 0, +1/4, +1/2
   localparam logic [3:0][1:0] SHIFT_BY_POS = {2'h2, 2'h1, 2'h0, 2'h3};

   // ------------------------------------------------------------------
   // Header layout
   // ------------------------------------------------------------------
   localparam int STAMP_W = 32;
   localparam int SEQ_W = 16;
   localparam int CNT_W = 8;
   localparam logic [5:0] HDR_RSVD = 6'h00;

   typedef enum logic [1:0] {
      IF_45 = 2'b00,
      IF_135 = 2'b01,
      IF_225 = 2'b10
   } gsp_if_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HEADER = 2'b01,
      ST_PAYLOAD = 2'b10
   } gsp_state_t;

   typedef struct packed {
      logic [CH_W-1:0] i;
      logic [CH_W-1:0] q;
   } gsp_chan_t;

   typedef struct packed {
      logic [SC_W-1:0] i;
      logic [SC_W-1:0] q;
   } gsp_sc_t;

   typedef struct packed {
      logic [STAMP_W-1:0] stamp;
      logic [SEQ_W-1:0] seq;
      logic [CNT_W-1:0] count;
      logic [5:0] rsvd;
      logic [1:0] dma;
   } gsp_hdr_t;

   typedef struct packed {
      logic hdr;
      logic last;
      logic [1:0] dma;
      logic [63:0] data;
   } gsp_word_t;
endpackage

// >>> src/gsp_skid_buffer.sv
/*
 * Two-entry buffer with valid/ready on both sides; outputs come from flops.
 * Assumes the filling side holds data while inValid is high and inReady low.
 */
`timescale 1ns/1ps
`default_nettype none
module gsp_skid_buffer #(
   parameter int W = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   logic skidValid;
   logic [W-1:0] skidData;
   logic next_outValid;
   logic next_skidValid;
   logic [W-1:0] next_outData;
   logic [W-1:0] next_skidData;

   always_comb begin
      next_outValid = outValid;
      next_outData = outData;
      next_skidValid = skidValid;
      next_skidData = skidData;
      if (!outValid || outReady) begin
         if (skidValid) begin
            next_outValid = 1'b1;
            next_outData = skidData;
            next_skidValid = 1'b0;
         end else begin
            next_outValid = inValid;
            next_outData = inData;
         end
      end else if (inValid && !skidValid) begin
         // Second entry catches the word taken while the receiver stalls
         next_skidValid = 1'b1;
         next_skidData = inData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         outValid <= 1'b0;
         outData <= '0;
         skidValid <= 1'b0;
         skidData <= '0;
      end else begin
         outValid <= next_outValid;
         outData <= next_outData;
         skidValid <= next_skidValid;
         skidData <= next_skidData;
      end
   end

   assign inReady = !skidValid;

   AST_BUF_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      outValid && !outReady |=> outValid && $stable(outData))
      else $error("buffered word changed or vanished under stall");
endmodule
`default_nettype wire

// >>> src/gsp_superchannel_mixer.sv
/*
 * Frequency-offsets and sums groups of channel samples into superchannel samples.
 * Assumes channels of a group arrive in position order, position 0 first.
 */
`timescale 1ns/1ps
`default_nettype none
module gsp_superchannel_mixer #(
   parameter int TAG_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   input wire gsp_pkg::gsp_chan_t inSample,
   input wire logic [1:0] inPos,
   input wire logic [1:0] inPhase,
   input wire logic inLastOfGroup,
   input wire logic [TAG_W-1:0] inTag,
   output logic outValid,
   output gsp_pkg::gsp_sc_t outSample,
   output logic [TAG_W-1:0] outTag
);
   import gsp_pkg::*;

   gsp_sc_t acc;
   gsp_sc_t next_acc;
   gsp_sc_t next_outSample;
   logic next_outValid;
   logic [TAG_W-1:0] next_outTag;
   logic [3:0] rotProd;
   logic [SC_W-1:0] xi;
   logic [SC_W-1:0] xq;
   gsp_sc_t rot;
   gsp_sc_t sum;

   always_comb begin
      // Quarter-rate offset times sample index needs only sign swaps
      rotProd = SHIFT_BY_POS[inPos] * inPhase;
      xi = SC_W'(signed'(inSample.i));
      xq = SC_W'(signed'(inSample.q));
      case (rotProd[1:0])
         2'h0: rot = '{i: xi, q: xq};
         2'h1: rot = '{i: -xq, q: xi};
         2'h2: rot = '{i: -xi, q: -xq};
         default: rot = '{i: xq, q: -xi};
      endcase
      // Two guard bits hold the four-way sum exactly
      sum.i = ((inPos == 2'h0) ? '0 : acc.i) + rot.i;
      sum.q = ((inPos == 2'h0) ? '0 : acc.q) + rot.q;
      next_acc = acc;
      next_outValid = 1'b0;
      next_outSample = outSample;
      next_outTag = outTag;
      if (inValid) begin
         next_acc = sum;
         if (inLastOfGroup) begin
            next_outValid = 1'b1;
            next_outSample = sum;
            next_outTag = inTag;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         acc <= '0;
         outValid <= 1'b0;
         outSample <= '0;
         outTag <= '0;
      end else begin
         acc <= next_acc;
         outValid <= next_outValid;
         outSample <= next_outSample;
         outTag <= next_outTag;
      end
   end

   AST_MIX_OUT: assert property (@(posedge clk_sys) disable iff (rst)
      outValid |-> $past(inValid) && $past(inLastOfGroup) && outTag == $past(inTag))
      else $error("superchannel sample without a closing channel");

   AST_MIX_UNSHIFTED: assert property (@(posedge clk_sys) disable iff (rst)
      inValid && inPos == 2'h0 && inPhase == 2'h0
      |=> acc.i == SC_W'(signed'($past(inSample.i))) && acc.q == SC_W'(signed'($past(inSample.q))))
      else $error("phase zero group opener was rotated");
endmodule
`default_nettype wire

// >>> src/gsp_packetizer.sv
/*
 * Output side of a four-bank channelizer: input routing, IF mixing, output
 * rate, superchannel forming, masking and header-first packet assembly.
 * Assumes channel samples arrive bank by bank in channel order, and that
 * the channel filters sit outside between the baseband and channel ports.
 */
`timescale 1ns/1ps
`default_nettype none
module gsp_packetizer #(
   parameter int PAY_DEPTH = 128
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [gsp_pkg::NUM_ADC-1:0][gsp_pkg::ADC_W-1:0] adcIn,
   input wire logic [gsp_pkg::NUM_BANKS-1:0][1:0] bankSrcSel,
   input wire gsp_pkg::gsp_if_t [gsp_pkg::NUM_BANKS-1:0] bankIfSel,
   output logic [gsp_pkg::NUM_BANKS-1:0][gsp_pkg::BB_W-1:0] bbI,
   output logic [gsp_pkg::NUM_BANKS-1:0][gsp_pkg::BB_W-1:0] bbQ,
   output logic rateTick,
   input wire logic chanValid,
   output logic chanReady,
   input wire logic [1:0] chanBank,
   input wire logic [gsp_pkg::IDX_W-1:0] chanIdx,
   input wire gsp_pkg::gsp_chan_t chanSample,
   input wire logic [gsp_pkg::NUM_BANKS-1:0][gsp_pkg::MASK_W-1:0] maskWord,
   output logic outValid,
   input wire logic outReady,
   output gsp_pkg::gsp_word_t outWord
);
   import gsp_pkg::*;

   localparam int PTR_W = $clog2(PAY_DEPTH);
   localparam int TAG_W = 2 + SC_IDX_W + 1;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (PAY_DEPTH < SC_LARGE) begin : g_bad_depth
      $error("PAY_DEPTH cannot hold a full bank");
   end
   if ((int'(CH_LARGE) + GROUP - 1) / GROUP != SC_LARGE ||
       (int'(CH_SMALL) + GROUP - 1) / GROUP != SC_SMALL) begin : g_bad_groups
      $error("superchannel counts disagree with channel counts");
   end

   // ------------------------------------------------------------------
   // Input routing and IF mixer, one per bank
   // ------------------------------------------------------------------
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic [1:0] ifPhase;
      logic [1:0] next_ifPhase;
      logic [BB_W-1:0] x;
      logic [BB_W-1:0] bi;
      logic [BB_W-1:0] bq;
      logic [BB_W-1:0] next_bi;
      logic [BB_W-1:0] next_bq;

      always_comb begin
         x = BB_W'(signed'(adcIn[bankSrcSel[b]]));
         // IF sits at fs/4, 3fs/4 or 5fs/4; the second zone (3fs/4, IF_135) is inverted, so it turns back
         next_ifPhase = (bankIfSel[b] == IF_135) ? ifPhase - 2'h1 : ifPhase + 2'h1;
         case (ifPhase)
            2'h0: begin
               next_bi = x;
               next_bq = '0;
            end
            2'h1: begin
               next_bi = '0;
               next_bq = -x;
            end
            2'h2: begin
               next_bi = -x;
               next_bq = '0;
            end
            default: begin
               next_bi = '0;
               next_bq = x;
            end
         endcase
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            ifPhase <= 2'h0;
            bi <= '0;
            bq <= '0;
         end else begin
            ifPhase <= next_ifPhase;
            bi <= next_bi;
            bq <= next_bq;
         end
      end

      assign bbI[b] = bi;
      assign bbQ[b] = bq;
   end

   AST_IF_ROTATE: assert property (
      g_bank[0].ifPhase == 2'h2 |=> bbI[0] == -BB_W'(signed'($past(adcIn[bankSrcSel[0]]))) && bbQ[0] == '0)
      else $error("bank 0 mixer output wrong at half turn");

   // ------------------------------------------------------------------
   // Output-rate tick and time stamp
   // ------------------------------------------------------------------
   logic [11:0] rateAcc;
   logic [11:0] next_rateAcc;
   logic [11:0] rateSum;
   logic next_rateTick;
   logic [STAMP_W-1:0] timeStamp;

   always_comb begin
      rateSum = rateAcc + RATE_NUM;
      if (rateSum >= RATE_DEN) begin
         next_rateAcc = rateSum - RATE_DEN;
         next_rateTick = 1'b1;
      end else begin
         next_rateAcc = rateSum;
         next_rateTick = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rateAcc <= '0;
         rateTick <= 1'b0;
         timeStamp <= '0;
      end else begin
         rateAcc <= next_rateAcc;
         rateTick <= next_rateTick;
         timeStamp <= timeStamp + 32'h1;
      end
   end

   logic [7:0] gapCnt;
   logic seenTick;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gapCnt <= 8'h0;
         seenTick <= 1'b0;
      end else begin
         gapCnt <= rateTick ? 8'h1 : gapCnt + 8'h1;
         seenTick <= seenTick | rateTick;
      end
   end

   AST_RATE_GAP: assert property (
      rateTick && seenTick |-> gapCnt == RATE_GAP_MIN || gapCnt == RATE_GAP_MAX)
      else $error("output-rate tick spacing off");

   // ------------------------------------------------------------------
   // Superchannel forming
   // ------------------------------------------------------------------
   logic accept;
   logic frameEndIn;
   logic [IDX_W-1:0] chanCount;
   logic [NUM_BANKS-1:0][1:0] scPhase;
   logic mixV;
   gsp_sc_t mixSample;
   logic [TAG_W-1:0] mixTag;
   logic [1:0] mixBank;
   logic [SC_IDX_W-1:0] mixSc;
   logic mixEnd;

   always_comb begin
      // Channel k of a bank sits at k times the 200 kHz spacing
      chanCount = LARGE_BANKS[chanBank] ? CH_LARGE : CH_SMALL;
      frameEndIn = chanIdx == chanCount - 9'h1;
      accept = chanValid && chanReady;
   end

   assign {mixBank, mixSc, mixEnd} = mixTag;

   gsp_superchannel_mixer #(.TAG_W(TAG_W)) u_mixer (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(accept),
      .inSample(chanSample),
      .inPos(chanIdx[1:0]),
      .inPhase(scPhase[chanBank]),
      .inLastOfGroup(chanIdx[1:0] == 2'h3 || frameEndIn),
      .inTag({chanBank, chanIdx[IDX_W-1:2], frameEndIn}),
      .outValid(mixV),
      .outSample(mixSample),
      .outTag(mixTag)
   );

   // ------------------------------------------------------------------
   // Ping-pong payload store and packet emitter
   // ------------------------------------------------------------------
   gsp_sc_t payMem [2][PAY_DEPTH];
   logic [MASK_W-1:0] maskLatched, next_maskLatched;
   logic fillSel, next_fillSel, emitSel, next_emitSel;
   logic [1:0] full, next_full;
   logic [PTR_W-1:0] wrIdx, next_wrIdx, rdIdx, next_rdIdx;
   logic [1:0][CNT_W-1:0] cnt, next_cnt;
   logic [1:0][STAMP_W-1:0] stamp, next_stamp;
   logic [1:0][1:0] bankOf, next_bankOf;
   logic [NUM_BANKS-1:0][SEQ_W-1:0] seqCnt, next_seqCnt;
   logic [NUM_BANKS-1:0][1:0] next_scPhase;
   gsp_state_t state, next_state;
   logic next_chanReady;
   logic memWe;
   logic bufInValid, bufInReady;
   gsp_word_t bufInWord;
   gsp_hdr_t hdr;

   always_comb begin
      next_maskLatched = maskLatched;
      next_fillSel = fillSel;
      next_emitSel = emitSel;
      next_full = full;
      next_wrIdx = wrIdx;
      next_rdIdx = rdIdx;
      next_cnt = cnt;
      next_stamp = stamp;
      next_bankOf = bankOf;
      next_seqCnt = seqCnt;
      next_scPhase = scPhase;
      next_state = state;
      if (accept && chanIdx == '0) begin
         // Mask sampled only when a bank's frame opens
         next_maskLatched = maskWord[chanBank];
         next_stamp[fillSel] = timeStamp;
         next_bankOf[fillSel] = chanBank;
      end
      memWe = mixV && maskLatched[mixSc];
      if (memWe) begin
         next_wrIdx = wrIdx + 1'b1;
      end
      if (mixV && mixEnd) begin
         next_full[fillSel] = 1'b1;
         next_cnt[fillSel] = CNT_W'(wrIdx) + CNT_W'(memWe);
         next_wrIdx = '0;
         next_fillSel = !fillSel;
         next_scPhase[mixBank] = scPhase[mixBank] + 2'h1;
      end
      hdr = '{stamp: stamp[emitSel], seq: seqCnt[bankOf[emitSel]], count: cnt[emitSel],
              rsvd: HDR_RSVD, dma: bankOf[emitSel]};
      bufInValid = 1'b0;
      bufInWord = '{hdr: 1'b0, last: 1'b0, dma: bankOf[emitSel],
                    data: {6'h00, payMem[emitSel][rdIdx].i, 6'h00, payMem[emitSel][rdIdx].q}};
      case (state)
         ST_IDLE: begin
            if (full[emitSel]) begin
               next_state = ST_HEADER;
            end
         end
         ST_HEADER: begin
            bufInValid = 1'b1;
            bufInWord = '{hdr: 1'b1, last: cnt[emitSel] == '0, dma: bankOf[emitSel], data: hdr};
            if (bufInReady) begin
               next_seqCnt[bankOf[emitSel]] = seqCnt[bankOf[emitSel]] + 16'h1;
               next_rdIdx = '0;
               if (cnt[emitSel] == '0) begin
                  next_full[emitSel] = 1'b0;
                  next_emitSel = !emitSel;
                  next_state = ST_IDLE;
               end else begin
                  next_state = ST_PAYLOAD;
               end
            end
         end
         ST_PAYLOAD: begin
            bufInValid = 1'b1;
            bufInWord.last = CNT_W'(rdIdx) == cnt[emitSel] - 8'h1;
            if (bufInReady) begin
               if (bufInWord.last) begin
                  next_full[emitSel] = 1'b0;
                  next_emitSel = !emitSel;
                  next_state = ST_IDLE;
               end else begin
                  next_rdIdx = rdIdx + 1'b1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // A frame end in flight holds input off until the halves have swapped
      next_chanReady = !next_full[next_fillSel] && !(accept && frameEndIn) && !(mixV && mixEnd);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         maskLatched <= '0;
         fillSel <= 1'b0;
         emitSel <= 1'b0;
         full <= '0;
         wrIdx <= '0;
         rdIdx <= '0;
         cnt <= '0;
         stamp <= '0;
         bankOf <= '0;
         seqCnt <= '0;
         scPhase <= '0;
         state <= ST_IDLE;
         chanReady <= 1'b0;
      end else begin
         maskLatched <= next_maskLatched;
         fillSel <= next_fillSel;
         emitSel <= next_emitSel;
         full <= next_full;
         wrIdx <= next_wrIdx;
         rdIdx <= next_rdIdx;
         cnt <= next_cnt;
         stamp <= next_stamp;
         bankOf <= next_bankOf;
         seqCnt <= next_seqCnt;
         scPhase <= next_scPhase;
         state <= next_state;
         chanReady <= next_chanReady;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (memWe) begin
         payMem[fillSel][wrIdx] <= mixSample;
      end
   end

   gsp_skid_buffer #(.W($bits(gsp_word_t))) u_outbuf (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(bufInWord),
      .outValid(outValid),
      .outReady(outReady),
      .outData(outWord)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   sequence hdrTaken;
      state == ST_HEADER && bufInReady;
   endsequence

   sequence payloadOpens;
      ##1 state == ST_PAYLOAD && rdIdx == '0;
   endsequence

   AST_HDR_FIRST: assert property (state == ST_PAYLOAD |-> $past(state) != ST_IDLE)
      else $error("payload began without a header");

   AST_HDR_THEN_PAY: assert property (hdrTaken ##0 cnt[emitSel] != '0 |-> payloadOpens)
      else $error("header with nonzero count not followed by payload");

   AST_SEQ_INC: assert property (hdrTaken |=> seqCnt[$past(bankOf[emitSel])] ==
      $past(seqCnt[bankOf[emitSel]]) + 16'h1)
      else $error("sequence count did not step by one");

   AST_READY_FRAME: assert property (accept && frameEndIn |=> !chanReady ##1 !chanReady)
      else $error("input taken across a frame swap");

   AST_LAST_GROUP: assert property (accept && frameEndIn |=> mixV && mixEnd)
      else $error("closing short group not emitted");

   AST_MASK_SKIP: assert property (mixV && !maskLatched[mixSc] |=> wrIdx == '0 || $stable(wrIdx))
      else $error("disabled superchannel stored");

   AST_SC_RANGE: assert property (mixV |-> int'(mixSc) <
      (LARGE_BANKS[mixBank] ? SC_LARGE : SC_SMALL))
      else $error("superchannel index out of range");
endmodule
`default_nettype wire

// >>> bench/gsp_dma_sink.sv
/* DMA-side partner: accepts packet words, stalling in a fixed pattern.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module gsp_dma_sink
   import gsp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic outValid,
   input wire gsp_pkg::gsp_word_t outWord,
   output logic outReady
);
   logic [9:0] tick;
   gsp_word_t got[$];
   initial begin
      tick = '0;
      outReady = 1'b0;
   end
   // Short and long stalls, so back-pressure reaches the packet emitter
   always @(negedge clk_sys) begin
      tick <= rst ? '0 : tick + 10'h1;
      outReady <= tick[2:0] != 3'h0 && tick[9:7] != 3'h5;
   end
   always @(posedge clk_sys) begin
      if (!rst && outValid && outReady) got.push_back(outWord);
   end
endmodule
`default_nettype wire

// >>> bench/gsp_packetizer_tb.sv
/* Bench top: routing, rate and two rounds of four bank frames.
   Assumes the sink model records every accepted word in order. */
`timescale 1ns/1ps
`default_nettype none
module gsp_packetizer_tb;
   import gsp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0][15:0] adcIn = {16'h0, 16'h0400, 16'h0, 16'h0};
   logic [3:0][1:0] bankSrcSel = {2'h2, 2'h0, 2'h2, 2'h1};
   gsp_if_t [3:0] bankIfSel = {IF_45, IF_225, IF_135, IF_45};
   logic [3:0][16:0] bbI, bbQ;
   logic rateTick, chanReady, outValid, outReady;
   logic chanValid = 1'b0;
   logic [1:0] chanBank = '0;
   logic [8:0] chanIdx = '0;
   gsp_chan_t chanSample = '0;
   logic [3:0][93:0] maskWord = '0;
   gsp_word_t outWord;
   gsp_word_t expQ[$];
   int err_count = 0;
   int check_count = 0;
   always #20 clk_sys = ~clk_sys;
   gsp_packetizer u_gsp_packetizer (.clk_sys(clk_sys), .rst(rst), .adcIn(adcIn),
      .bankSrcSel(bankSrcSel), .bankIfSel(bankIfSel), .bbI(bbI), .bbQ(bbQ),
      .rateTick(rateTick), .chanValid(chanValid), .chanReady(chanReady),
      .chanBank(chanBank), .chanIdx(chanIdx), .chanSample(chanSample),
      .maskWord(maskWord), .outValid(outValid), .outReady(outReady), .outWord(outWord));
   gsp_dma_sink u_gsp_dma_sink (.clk_sys(clk_sys), .rst(rst), .outValid(outValid),
      .outWord(outWord), .outReady(outReady));
   // ------------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------------
   task automatic check(string name, logic [67:0] seen, logic [67:0] expv);
      check_count++;
      if (seen !== expv) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, expv, seen);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Only converter 2 carries signal, so only banks fed from it move
   task automatic bb_check();
      logic [3:0] seen;
      seen = '0;
      repeat (24) begin
         @(negedge clk_sys);
         for (int b = 0; b < 4; b++) seen[b] = seen[b] | (|{bbI[b], bbQ[b]});
      end
      check("bank activity", 68'(seen), 68'h0a);
   endtask
   task automatic rate_check();
      int t;
      t = 0;
      repeat (2160) begin
         @(negedge clk_sys);
         t += int'(rateTick);
      end
      check("rate ticks", 68'(t), 68'd13);
   endtask
   // ------------------------------------------------------------------
   // One bank frame plus its expected packet
   // ------------------------------------------------------------------
   task automatic send_frame(int b, int r);
      int n, k, p, x, y, ci, cq, cnt, nch, rot;
      logic [93:0] m;
      gsp_word_t w;
      nch = b < 2 ? 375 : 175;
      m = b == 0 ? {47{2'b10}} : b == 1 ? 94'(r) : b == 2 ? 94'hfff_ffff_ffff : 94'h800_0000_0001;
      if (r == 1 && b == 0) m = ~m;
      for (int i = 0; i < nch; i++) begin
         @(negedge clk_sys);
         if (i == 0) maskWord[b] = m;
         if (i == 1) maskWord[b] = ~m;
         chanValid = 1'b1;
         chanBank = 2'(b);
         chanIdx = 9'(i);
         chanSample = '{i: 24'(i + 16 * b), q: 24'(-i - 1)};
         for (n = 0; n < 2000 && chanReady !== 1'b1; n++) @(negedge clk_sys);
         if (chanReady !== 1'b1) begin
            err_count++;
            summarize();
         end
         @(posedge clk_sys);
      end
      @(negedge clk_sys);
      chanValid = 1'b0;
      cnt = 0;
      for (k = 0; k < (nch + 3) / 4; k++) cnt += int'(m[k]);
      w = '0;
      w.hdr = 1'b1;
      w.last = cnt == 0;
      w.dma = 2'(b);
      w.data[31:0] = {16'(r), 8'(cnt), 6'h0, 2'(b)};
      expQ.push_back(w);
      for (k = 0; k < (nch + 3) / 4; k++) begin
         if (m[k]) begin
            ci = 0;
            cq = 0;
            for (p = 0; p < 4 && 4 * k + p < nch; p++) begin
               rot = (int'(SHIFT_BY_POS[p]) * r) % 4;
               x = 4 * k + p + 16 * b;
               y = -(4 * k + p) - 1;
               case (rot)
                  0: begin ci += x; cq += y; end
                  1: begin ci -= y; cq += x; end
                  2: begin ci -= x; cq -= y; end
                  default: begin ci += y; cq -= x; end
               endcase
            end
            cnt--;
            w = '0;
            w.last = cnt == 0;
            w.dma = 2'(b);
            w.data = {6'h0, 26'(ci), 6'h0, 26'(cq)};
            expQ.push_back(w);
         end
      end
   endtask
   initial begin
      int n;
      logic [31:0] ps;
      gsp_word_t g;
      ps = '0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      bb_check();
      rate_check();
      for (int r = 0; r < 2; r++) for (int b = 0; b < 4; b++) send_frame(b, r);
      for (n = 0; n < 20000 && u_gsp_dma_sink.got.size() < expQ.size(); n++) @(negedge clk_sys);
      repeat (50) @(negedge clk_sys);
      check("word count", 68'(u_gsp_dma_sink.got.size()), 68'(expQ.size()));
      foreach (expQ[i]) begin
         g = u_gsp_dma_sink.got[i];
         if (g.hdr && expQ[i].hdr) begin
            // Stamps are latched at each frame's opening, so they only grow
            check("stamp order", 68'(g.data[63:32] > ps), 68'h1);
            ps = g.data[63:32];
         end
         if (g.hdr) g.data[63:32] = '0;
         check("packet word", g, expQ[i]);
      end
      summarize();
   end
endmodule
`default_nettype wire
